// ==== design/btg_fifo.sv ====
// btg_fifo.sv: synchronous sample FIFO with valid/ready on both sides.
// assumes: single clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module btg_fifo
  import btg_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_fill;
  logic             doPush;
  logic             doPop;

  // honest full and empty flags
  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // pointer and fill level update
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_fill  = fill;
    if (doPush) begin
      next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
    if (doPop) begin
      next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    end
    case ({doPush, doPop})
      2'b10:   next_fill = fill + 1'b1;
      2'b01:   next_fill = fill - 1'b1;
      default: next_fill = fill;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill  <= next_fill;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule : btg_fifo

`default_nettype wire

// ==== design/btg_level_gain.sv ====
// btg_level_gain.sv: scales a sample by the six-bit tone level code.
// assumes: purely combinational, result registered by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "btg_params.svh"

module btg_level_gain
  import btg_pkg::*;
(
  // level code and sample in
  input  wire logic [5:0]  level,
  input  wire btg_sample_t sampleIn,
  // scaled sample out
  output var btg_sample_t  sampleOut
);

  logic [6:0]         atten;
  logic [6:0]         shift;
  logic [6:0]         frac;
  logic signed [16:0] mant;
  logic signed [33:0] product;
  logic signed [33:0] scaled;

  // attenuation from +6 dB: whole 6 dB steps shift, rest from a table
  always_comb begin
    atten = {1'b0, level} + `BTG_LEVEL_OFFSET_DB;
    shift = atten / `BTG_DB_PER_SHIFT;
    frac  = atten % `BTG_DB_PER_SHIFT;
    case (frac)
      7'h00:   mant = 17'sh07FFF;
      7'h01:   mant = 17'sh0721D;
      7'h02:   mant = 17'sh065AD;
      7'h03:   mant = 17'sh05A9E;
      7'h04:   mant = 17'sh050C3;
      7'h05:   mant = 17'sh047FB;
      default: mant = 17'sh07FFF;
    endcase
    product = 34'(sampleIn * mant);
    scaled  = product >>> (7'(`BTG_FRAC_BITS - 1) + shift);
    if (scaled > 34'sh0000_7FFF) begin
      sampleOut = 16'sh7FFF;
    end else if (scaled < -34'sh0000_8000) begin
      sampleOut = -16'sh8000;
    end else begin
      sampleOut = scaled[15:0];
    end
  end

endmodule : btg_level_gain

`default_nettype wire

// ==== design/btg_params.svh ====
// btg_params.svh: register offsets, reset values, field positions and
// fixed constants of the tone generator.
// assumes: included by bare name from the package, btg_level_gain and btg_tone_generator.
//
// Behaviour
// - D7 starts tone, self-clears after duration
// - level code: +2 dB, minus 1 dB per step
// - tone only in DAC processing mode 25
// - duration = high, middle, low byte registers
// - exactly duration samples; reset length 0x0000EE
// - sine coefficient byte pair, reset 0x10D8
// - cosine coefficient byte pair, reset 0x7EE3
// - oscillator advances once per DAC sample
`ifndef BTG_PARAMS_SVH
`define BTG_PARAMS_SVH

// register offsets
`define BTG_OFS_CONTROL      8'h47
`define BTG_OFS_SPARE_CTRL   8'h48
`define BTG_OFS_LEN_HIGH     8'h49
`define BTG_OFS_LEN_MIDDLE   8'h4A
`define BTG_OFS_LEN_LOW      8'h4B
`define BTG_OFS_SINE_HIGH    8'h4C
`define BTG_OFS_SINE_LOW     8'h4D
`define BTG_OFS_COSINE_HIGH  8'h4E
`define BTG_OFS_COSINE_LOW   8'h4F
`define BTG_OFS_SPARE_COS    8'h50

// reset values
`define BTG_RST_CONTROL      8'h00
`define BTG_RST_SPARE_CTRL   8'h00
`define BTG_RST_LEN_HIGH     8'h00
`define BTG_RST_LEN_MIDDLE   8'h00
`define BTG_RST_LEN_LOW      8'hEE
`define BTG_RST_SINE_HIGH    8'h10
`define BTG_RST_SINE_LOW     8'hD8
`define BTG_RST_COSINE_HIGH  8'h7E
`define BTG_RST_COSINE_LOW   8'hE3
`define BTG_RST_SPARE_COS    8'h00

// control register fields
`define BTG_CTRL_ENABLE_BIT  7
`define BTG_CTRL_RSVD_BIT    6
`define BTG_CTRL_LEVEL_MSB   5
`define BTG_CTRL_LEVEL_LSB   0

// playback processing mode that carries the tone
`define BTG_DAC_MODE_TONE    5'h19

// oscillator and level scaling
`define BTG_START_AMPLITUDE  16'sh7FFF
`define BTG_FRAC_BITS        15
`define BTG_LEVEL_OFFSET_DB  7'h04
`define BTG_DB_PER_SHIFT     7'h06

// sample buffer
`define BTG_SAMPLE_WIDTH     16
`define BTG_FIFO_DEPTH       16

`endif

// ==== design/btg_pkg.sv ====
// btg_pkg.sv: types shared by the tone generator modules.
// assumes: btg_params.svh is on the include path.
`include "btg_params.svh"

package btg_pkg;

  typedef enum logic [1:0] {
    BTG_IDLE,
    BTG_RUN,
    BTG_PUSH
  } btg_state_t;

  typedef logic signed [`BTG_SAMPLE_WIDTH-1:0] btg_sample_t;

endpackage : btg_pkg

// ==== design/btg_tone_generator.sv ====
// btg_tone_generator.sv: byte register file, sine oscillator, duration
// counter and 16-word output buffer of the tone generator.
// assumes: byte register port synchronous to clock, one DAC sample
// strobe per sample period, consumer drains the tone stream.
`timescale 1ns/1ps
`default_nettype none
`include "btg_params.svh"

module btg_tone_generator
  import btg_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // byte register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRead,
  output logic [7:0]       regRdData,
  // playback path context
  input  wire logic [4:0]  dacProcessingMode,
  input  wire logic        sampleTick,
  // tone sample stream
  output logic             toneValid,
  input  wire logic        toneReady,
  output logic [15:0]      toneData,
  // status
  output logic             toneActive
);

  // register contents
  logic        ctrlEnable;
  logic        ctrlReserved;
  logic [5:0]  ctrlLevel;
  logic [7:0]  spareCtrl;
  logic [7:0]  lenHigh;
  logic [7:0]  lenMiddle;
  logic [7:0]  lenLow;
  logic [7:0]  sineHigh;
  logic [7:0]  sineLow;
  logic [7:0]  cosineHigh;
  logic [7:0]  cosineLow;
  logic [7:0]  spareCos;
  logic        next_ctrlEnable;
  logic        next_ctrlReserved;
  logic [5:0]  next_ctrlLevel;
  logic [7:0]  next_spareCtrl;
  logic [7:0]  next_lenHigh;
  logic [7:0]  next_lenMiddle;
  logic [7:0]  next_lenLow;
  logic [7:0]  next_sineHigh;
  logic [7:0]  next_sineLow;
  logic [7:0]  next_cosineHigh;
  logic [7:0]  next_cosineLow;
  logic [7:0]  next_spareCos;
  logic [7:0]  next_regRdData;

  // generator state
  btg_state_t  state;
  btg_state_t  next_state;
  logic [23:0] remaining;
  logic [23:0] next_remaining;
  btg_sample_t oscX;
  btg_sample_t oscY;
  btg_sample_t next_oscX;
  btg_sample_t next_oscY;
  btg_sample_t pendData;
  btg_sample_t next_pendData;
  logic        hwClear;

  // derived values
  logic [23:0]        lengthWord;
  btg_sample_t        sineCoef;
  btg_sample_t        cosineCoef;
  logic               modeOk;
  logic signed [32:0] rotX;
  logic signed [32:0] rotY;
  btg_sample_t        scaledY;
  logic               fifoInValid;
  logic               fifoInReady;

  assign lengthWord = {lenHigh, lenMiddle, lenLow};
  assign sineCoef   = {sineHigh, sineLow};
  assign cosineCoef = {cosineHigh, cosineLow};
  assign modeOk     = (dacProcessingMode == `BTG_DAC_MODE_TONE);
  assign toneActive = (state != BTG_IDLE);

  // saturate a Q2.30 sum back to a Q1.15 sample
  function automatic btg_sample_t sat_q15(input logic signed [32:0] v);
    logic signed [32:0] s;
    s = v >>> `BTG_FRAC_BITS;
    if (s > 33'sh0000_7FFF) begin
      sat_q15 = 16'sh7FFF;
    end else if (s < -33'sh0000_8000) begin
      sat_q15 = -16'sh8000;
    end else begin
      sat_q15 = s[15:0];
    end
  endfunction : sat_q15

  // one rotation step of the coupled oscillator
  always_comb begin
    rotX = 33'(oscX * cosineCoef) - 33'(oscY * sineCoef);
    rotY = 33'(oscX * sineCoef) + 33'(oscY * cosineCoef);
  end

  // level scaling of the current sine output
  btg_level_gain u_level (
    .level     (ctrlLevel),
    .sampleIn  (oscY),
    .sampleOut (scaledY)
  );

  // register writes; a software set beats the self-clear
  always_comb begin
    next_ctrlEnable   = hwClear ? 1'b0 : ctrlEnable;
    next_ctrlReserved = ctrlReserved;
    next_ctrlLevel    = ctrlLevel;
    next_spareCtrl    = spareCtrl;
    next_lenHigh      = lenHigh;
    next_lenMiddle    = lenMiddle;
    next_lenLow       = lenLow;
    next_sineHigh     = sineHigh;
    next_sineLow      = sineLow;
    next_cosineHigh   = cosineHigh;
    next_cosineLow    = cosineLow;
    next_spareCos     = spareCos;
    if (regWrite) begin
      case (regAddr)
        `BTG_OFS_CONTROL: begin
          next_ctrlEnable   = regWrData[`BTG_CTRL_ENABLE_BIT];
          next_ctrlReserved = regWrData[`BTG_CTRL_RSVD_BIT];
          next_ctrlLevel    =
            regWrData[`BTG_CTRL_LEVEL_MSB:`BTG_CTRL_LEVEL_LSB];
        end
        `BTG_OFS_SPARE_CTRL:  next_spareCtrl  = regWrData;
        `BTG_OFS_LEN_HIGH:    next_lenHigh    = regWrData;
        `BTG_OFS_LEN_MIDDLE:  next_lenMiddle  = regWrData;
        `BTG_OFS_LEN_LOW:     next_lenLow     = regWrData;
        `BTG_OFS_SINE_HIGH:   next_sineHigh   = regWrData;
        `BTG_OFS_SINE_LOW:    next_sineLow    = regWrData;
        `BTG_OFS_COSINE_HIGH: next_cosineHigh = regWrData;
        `BTG_OFS_COSINE_LOW:  next_cosineLow  = regWrData;
        `BTG_OFS_SPARE_COS:   next_spareCos   = regWrData;
        default: ;
      endcase
    end
  end

  // read data, registered; unmapped offsets read zero
  always_comb begin
    next_regRdData = regRdData;
    if (regRead) begin
      case (regAddr)
        `BTG_OFS_CONTROL:
          next_regRdData = {ctrlEnable, ctrlReserved, ctrlLevel};
        `BTG_OFS_SPARE_CTRL:  next_regRdData = spareCtrl;
        `BTG_OFS_LEN_HIGH:    next_regRdData = lenHigh;
        `BTG_OFS_LEN_MIDDLE:  next_regRdData = lenMiddle;
        `BTG_OFS_LEN_LOW:     next_regRdData = lenLow;
        `BTG_OFS_SINE_HIGH:   next_regRdData = sineHigh;
        `BTG_OFS_SINE_LOW:    next_regRdData = sineLow;
        `BTG_OFS_COSINE_HIGH: next_regRdData = cosineHigh;
        `BTG_OFS_COSINE_LOW:  next_regRdData = cosineLow;
        `BTG_OFS_SPARE_COS:   next_regRdData = spareCos;
        default:              next_regRdData = 8'h00;
      endcase
    end
  end

  // register file storage with documented reset values
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlEnable   <= 1'(`BTG_RST_CONTROL >> `BTG_CTRL_ENABLE_BIT);
      ctrlReserved <= 1'b0;
      ctrlLevel    <= 6'h00;
      spareCtrl    <= `BTG_RST_SPARE_CTRL;
      lenHigh      <= `BTG_RST_LEN_HIGH;
      lenMiddle    <= `BTG_RST_LEN_MIDDLE;
      lenLow       <= `BTG_RST_LEN_LOW;
      sineHigh     <= `BTG_RST_SINE_HIGH;
      sineLow      <= `BTG_RST_SINE_LOW;
      cosineHigh   <= `BTG_RST_COSINE_HIGH;
      cosineLow    <= `BTG_RST_COSINE_LOW;
      spareCos     <= `BTG_RST_SPARE_COS;
      regRdData    <= 8'h00;
    end else begin
      ctrlEnable   <= next_ctrlEnable;
      ctrlReserved <= next_ctrlReserved;
      ctrlLevel    <= next_ctrlLevel;
      spareCtrl    <= next_spareCtrl;
      lenHigh      <= next_lenHigh;
      lenMiddle    <= next_lenMiddle;
      lenLow       <= next_lenLow;
      sineHigh     <= next_sineHigh;
      sineLow      <= next_sineLow;
      cosineHigh   <= next_cosineHigh;
      cosineLow    <= next_cosineLow;
      spareCos     <= next_spareCos;
      regRdData    <= next_regRdData;
    end
  end

  // sequencer: start, one step per sample tick, push, self-clear
  always_comb begin
    next_state     = state;
    next_remaining = remaining;
    next_oscX      = oscX;
    next_oscY      = oscY;
    next_pendData  = pendData;
    hwClear        = 1'b0;
    fifoInValid    = 1'b0;
    case (state)
      BTG_IDLE: begin
        if (ctrlEnable && modeOk) begin
          if (lengthWord == 24'h000000) begin
            hwClear = 1'b1;
          end else begin
            next_remaining = lengthWord;
            next_oscX      = `BTG_START_AMPLITUDE;
            next_oscY      = 16'sh0000;
            next_state     = BTG_RUN;
          end
        end
      end
      BTG_RUN: begin
        if (sampleTick) begin
          if (!ctrlEnable || !modeOk) begin
            next_state = BTG_IDLE;
          end else begin
            next_pendData  = scaledY;
            next_oscX      = sat_q15(rotX);
            next_oscY      = sat_q15(rotY);
            next_remaining = remaining - 24'h000001;
            next_state     = BTG_PUSH;
          end
        end
      end
      BTG_PUSH: begin
        fifoInValid = 1'b1;
        if (fifoInReady) begin
          if (remaining == 24'h000000) begin
            hwClear    = 1'b1;
            next_state = BTG_IDLE;
          end else begin
            next_state = BTG_RUN;
          end
        end
      end
      default: next_state = BTG_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= BTG_IDLE;
      remaining <= 24'h000000;
      oscX      <= 16'sh0000;
      oscY      <= 16'sh0000;
      pendData  <= 16'sh0000;
    end else begin
      state     <= next_state;
      remaining <= next_remaining;
      oscX      <= next_oscX;
      oscY      <= next_oscY;
      pendData  <= next_pendData;
    end
  end

  // 16-word buffer between oscillator and playback stream
  btg_fifo #(
    .WIDTH (`BTG_SAMPLE_WIDTH),
    .DEPTH (`BTG_FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .srst     (srst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (pendData),
    .outValid (toneValid),
    .outReady (toneReady),
    .outData  (toneData)
  );

endmodule : btg_tone_generator

`default_nettype wire

// ==== verification/btg_tone_generator_assertions.sv ====
// btg_tone_generator_assertions.sv: port-level checks of the tone generator
// assumes: bound onto btg_tone_generator from the bench top file
`timescale 1ns/1ps
`default_nettype none

module btg_tone_generator_assertions
  import btg_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // byte register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic [7:0]  regWrData,
  input wire logic        regRead,
  input wire logic [7:0]  regRdData,
  // playback path context
  input wire logic [4:0]  dacProcessingMode,
  input wire logic        sampleTick,
  // tone stream and status
  input wire logic        toneValid,
  input wire logic        toneReady,
  input wire logic [15:0] toneData,
  input wire logic        toneActive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // outputs quiet after a reset edge
  property p_reset_quiet;
    disable iff (1'b0) srst |=> !toneValid && !toneActive &&
      regRdData == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");

  // a new sample needs a tick in mode 25 two edges earlier
  property p_tone_from_tick;
    $rose(toneValid) |-> $past(sampleTick, 2) &&
      $past(dacProcessingMode, 2) == 5'h19;
  endproperty
  a_tone_from_tick: assert property (p_tone_from_tick)
    else $error("sample appeared without tick in tone mode");

  // samples are pushed only while the generator runs
  property p_push_needs_active;
    $rose(toneValid) |-> $past(toneActive);
  endproperty
  a_push_needs_active: assert property (p_push_needs_active)
    else $error("sample pushed while idle");

  // generator starts only in mode 25
  property p_start_mode;
    $rose(toneActive) |-> $past(dacProcessingMode) == 5'h19;
  endproperty
  a_start_mode: assert property (p_start_mode)
    else $error("generator started outside tone mode");

  // unmapped offsets read as zero
  property p_unmapped_zero;
    regRead && (regAddr < 8'h47 || regAddr > 8'h50) |=> regRdData == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // read data holds between reads
  property p_read_holds;
    !regRead |=> $stable(regRdData);
  endproperty
  a_read_holds: assert property (p_read_holds)
    else $error("read data changed without read");

  // a written byte reads back two cycles later
  property p_write_readback;
    (regWrite && regAddr inside {[8'h48:8'h50]}) ##1 !regWrite
      ##1 (regRead && regAddr == $past(regAddr, 2))
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("register readback differs from write");

  // offered sample holds while stalled
  property p_valid_holds;
    toneValid && !toneReady |=> toneValid && $stable(toneData);
  endproperty
  a_valid_holds: assert property (p_valid_holds)
    else $error("stalled sample changed");

  // clearing the enable stops the generator soon
  property p_clear_stops;
    regWrite && regAddr == 8'h47 && !regWrData[7] |-> ##[1:300] !toneActive;
  endproperty
  a_clear_stops: assert property (p_clear_stops)
    else $error("generator kept running after clear");
endmodule : btg_tone_generator_assertions

`default_nettype wire

// ==== verification/btg_tone_generator_tb_top.sv ====
// btg_tone_generator_tb_top.sv: self-checking bench of the tone generator
// assumes: design files and the checker file are compiled first
`timescale 1ns/1ps
`default_nettype none

module btg_tone_generator_tb_top;
  // bench signals
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic        regWrite = 1'b0;
  logic [7:0]  regWrData = 8'h00;
  logic        regRead = 1'b0;
  logic [7:0]  regRdData;
  logic [4:0]  dacProcessingMode = 5'h19;
  logic        sampleTick = 1'b0;
  logic        toneValid;
  logic        toneReady = 1'b0;
  logic [15:0] toneData;
  logic        toneActive;
  logic        readyOn = 1'b1;
  logic [7:0]  rd;
  logic [7:0]  wv;
  logic [15:0] got[$];
  logic [7:0]  rstTab[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE, 8'h10,
                              8'hD8, 8'h7E, 8'hE3, 8'h00, 8'h00};
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          m0;

  btg_tone_generator u_btg_tone_generator (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .dacProcessingMode(dacProcessingMode), .sampleTick(sampleTick),
    .toneValid(toneValid), .toneReady(toneReady), .toneData(toneData),
    .toneActive(toneActive));

  // 100 MHz clock
  always #5 clock = ~clock;

  // consumer with random stalls
  always @(negedge clock) toneReady <= readyOn && ($urandom_range(0, 1) == 1);

  // sample capture and cycle ceiling
  always @(posedge clock) begin
    if (toneValid && toneReady) got.push_back(toneData);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] act);
    comparisons++;
    if (act !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, act);
      error_cnt++;
    end
  endtask : check

  // model: Q15 rotation from zero phase, 0 dB level within one LSB
  task automatic tone_model(input int n);
    longint      x;
    longint      y;
    longint      t;
    logic [15:0] act;
    x = 32767;
    y = 0;
    for (int k = 0; k < n; k++) begin
      t = longint'($signed(got[k])) - y;
      act = (t >= -1 && t <= 1) ? 16'(y) : got[k];
      check("tone sample", 16'(y), act);
      t = (x * 32'sh7EE3 - y * 32'sh10D8) >>> 15;
      y = (x * 32'sh10D8 + y * 32'sh7EE3) >>> 15;
      x = t;
    end
  endtask : tone_model

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    d = regRdData;
  endtask : reg_rd

  // one-cycle ticks, two to four cycles apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clock);
      sampleTick = 1'b1;
      @(negedge clock);
      sampleTick = 1'b0;
      repeat ($urandom_range(1, 3)) @(negedge clock);
    end
  endtask : ticks

  task automatic start(input logic [23:0] len, input logic [5:0] lvl);
    got.delete();
    reg_wr(8'h49, len[23:16]);
    reg_wr(8'h4A, len[15:8]);
    reg_wr(8'h4B, len[7:0]);
    reg_wr(8'h47, {2'b10, lvl});
  endtask : start

  // wait until generator idle and buffer empty
  task automatic drain();
    for (int i = 0; i < 300; i++) begin
      if (!toneActive && !toneValid) break;
      @(negedge clock);
    end
    repeat (2) @(negedge clock);
  endtask : drain

  // checks: count, zero-phase first sample, enable state, generator idle
  task automatic done(input int n, input logic en);
    check("sample count", n[15:0], 16'(got.size()));
    if (n > 0) check("first sample", 16'h0000, got[0]);
    reg_rd(8'h47, rd);
    check("enable bit", {15'h0, en}, {15'h0, rd[7]});
    check("generator idle", 16'h0, {15'h0, toneActive});
  endtask : done

  task automatic run(input logic [23:0] len, input logic [5:0] lvl,
                     input int n);
    start(len, lvl);
    ticks(n);
    drain();
  endtask : run

  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    void'($urandom(29136));
    repeat (20) @(negedge clock);
    srst = 1'b0;
    // reset values, unmapped offset last
    for (int i = 0; i < 11; i++) begin
      reg_rd(8'h47 + i[7:0], rd);
      check("reset value", {8'h00, rstTab[i]}, {8'h00, rd});
    end
    // random write and readback
    for (int i = 1; i < 10; i++) begin
      wv = (i == 1 || i == 9) ? 8'h00 : 8'($urandom);
      reg_wr(8'h47 + i[7:0], wv);
      reg_rd(8'h47 + i[7:0], rd);
      check("readback", {8'h00, wv}, {8'h00, rd});
    end
    for (int i = 5; i < 9; i++) reg_wr(8'h47 + i[7:0], rstTab[i]);
    // plain runs: short, two-byte length, zero length
    run(24'h000005, 6'h02, 8);
    done(5, 1'b0);
    tone_model(5);
    run(24'h000104, 6'($urandom), 263);
    done(260, 1'b0);
    run(24'h000000, 6'h00, 3);
    done(0, 1'b0);
    // loudest level against quietest
    run(24'h000004, 6'h00, 5);
    m0 = ($signed(got[1]) < 0) ? -$signed(got[1]) : $signed(got[1]);
    run(24'h000004, 6'h3F, 5);
    check("level order", 16'h1, {15'h0, m0 > (($signed(got[1]) < 0) ?
      -$signed(got[1]) : $signed(got[1]))});
    // other processing mode: no tone, enable stays
    dacProcessingMode = 5'h14;
    run(24'h000005, 6'h00, 8);
    done(0, 1'b1);
    reg_wr(8'h47, 8'h00);
    dacProcessingMode = 5'h19;
    // buffer fill with consumer stopped, then drain
    readyOn = 1'b0;
    start(24'h000014, 6'h00);
    ticks(30);
    check("buffer full valid", 16'h1, {15'h0, toneValid});
    check("nothing taken", 16'h0, 16'(got.size()));
    check("active while stalled", 16'h1, {15'h0, toneActive});
    readyOn = 1'b1;
    ticks(10);
    drain();
    done(20, 1'b0);
    // early clear, then reload on restart
    start(24'h000064, 6'h00);
    ticks(5);
    reg_wr(8'h47, 8'h00);
    ticks(5);
    drain();
    check("early stop", 16'h1, {15'h0, got.size() inside {5, 6}});
    run(24'h000003, 6'h00, 6);
    done(3, 1'b0);
    finish_test();
  end
endmodule : btg_tone_generator_tb_top

bind btg_tone_generator btg_tone_generator_assertions
  u_btg_tone_generator_assertions (
  .clock(clock), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
  .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
  .dacProcessingMode(dacProcessingMode), .sampleTick(sampleTick),
  .toneValid(toneValid), .toneReady(toneReady), .toneData(toneData),
  .toneActive(toneActive));

`default_nettype wire
